//--- rss_sequencer.sv
// Purpose: reset pin qualification, strap capture, config load, clock release
// Assumes: clk is the system oscillator; straps are pins, synchronised here
// Notes: registers on avalon-mm, one wait cycle on every access
`timescale 1ns/1ps

// Notes on behaviour
// - sample straps after release; board holds 2 ms
// - eeprom path: stable clocks within 100 ms
// - bad load retried; third failure halts
// - no eeprom: stable clocks within 10 ms
// - oscillator strap code picks nominal frequency
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int RST_MIN = RST_MIN_CYC,
  parameter int STRAP_SAMPLE = STRAP_SAMPLE_CYC,
  parameter int EE_BOUND = EE_LOAD_CYC,
  parameter int NO_EE_BOUND = NO_EE_CYC,
  parameter int LOAD_TIMEOUT = LOAD_TIMEOUT_CYC,
  parameter int LOCK = LOCK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic chip_reset_low,
  input wire logic [2:0] osc_freq_select,
  input wire logic [1:0] host_port_select,
  input wire logic [1:0] bus_addr_strap,
  input wire logic redundancy_role_strap,
  input wire logic framing_standard_strap,
  output logic ee_start,
  input wire logic ee_done,
  input wire logic ee_err,
  output logic core_reset_low,
  output logic clk_out_enable,
  output logic clocks_stable,
  output logic device_halted,
  output logic [rss_pkg::STRAP_W-1:0] strap_value
);
  import rss_pkg::*;

  if (RST_MIN < 1 || RST_MIN >= (1 << 16)) begin : g_bad_rst
    $error("bad RST_MIN");
  end
  if (STRAP_SAMPLE < 1 || EE_BOUND < 1 || NO_EE_BOUND < 1) begin : g_bad_bound
    $error("bad bound");
  end
  if (3 * EE_BOUND >= (1 << CNT_W)) begin : g_bad_width
    $error("EE_BOUND too wide");
  end
  if (LOCK < 1 || LOCK >= (1 << CNT_W)) begin : g_bad_lock
    $error("bad LOCK");
  end

  rss_ee_if ee_bus();

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic pin_low;
  logic [STRAP_W-1:0] straps_now;

  // pin_low resets high: an unknown pin must look asserted
  assign pins_raw = {chip_reset_low, framing_standard_strap, redundancy_role_strap,
                     bus_addr_strap, host_port_select, osc_freq_select};

  rss_sync #(
    .W(SYNC_W),
    .RST_VAL({1'b0, STRAP_RST})
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(pins_raw),
    .q(pins_s)
  );

  assign pin_low = ~pins_s[SYNC_W-1];
  assign straps_now = pins_s[STRAP_W-1:0];

  rss_ee_loader #(
    .TIMEOUT_CYC(LOAD_TIMEOUT),
    .MAX_ATT(EE_MAX_ATTEMPTS)
  ) u_ldr (
    .clk(clk),
    .nrst(nrst),
    .ee(ee_bus.ldr),
    .ee_start(ee_start),
    .ee_done(ee_done),
    .ee_err(ee_err)
  );

  // sequencer state
  rss_state_e st_q, st_d;
  logic [15:0] low_cnt_q, low_cnt_d;
  logic armed_q, armed_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] lock_q, lock_d;
  logic [STRAP_W-1:0] straps_q, straps_d;
  logic ee_use_q, ee_use_d;
  logic core_run_q, core_run_d;
  logic clk_en_q, clk_en_d;
  logic stable_q, stable_d;
  logic halt_q, halt_d;
  logic late_q, late_d;
  logic ctrl_ee_en_q, ctrl_ee_en_d;
  logic [CNT_W-1:0] bound;

  // later attempts stretch the deadline by one load each
  always_comb begin
    bound = CNT_W'(NO_EE_BOUND);
    if (ee_use_q) begin
      unique case (ee_bus.attempts)
        2'h2: bound = CNT_W'(2 * EE_BOUND);
        2'h3: bound = CNT_W'(3 * EE_BOUND);
        default: bound = CNT_W'(EE_BOUND);
      endcase
    end
  end

  always_comb begin
    st_d = st_q;
    low_cnt_d = low_cnt_q;
    armed_d = armed_q;
    cnt_d = cnt_q;
    lock_d = lock_q;
    straps_d = straps_q;
    ee_use_d = ee_use_q;
    core_run_d = core_run_q;
    clk_en_d = clk_en_q;
    stable_d = stable_q;
    halt_d = halt_q;
    late_d = late_q;
    ee_bus.start = (st_q == ST_LOAD);

    // a short low pulse is a glitch, not a reset
    if (pin_low) begin
      if (low_cnt_q != 16'(RST_MIN)) begin
        low_cnt_d = low_cnt_q + 16'h1;
      end
    end else begin
      low_cnt_d = 16'h0;
    end
    if (pin_low && low_cnt_q == 16'(RST_MIN - 1)) begin
      armed_d = 1'b1;
    end

    if (st_q != ST_HOLD && st_q != ST_READY && st_q != ST_HALT) begin
      if (cnt_q != {CNT_W{1'b1}}) begin
        cnt_d = cnt_q + 1'b1;
      end
    end

    // counting only advances on this clock, so a dead oscillator never arms
    // a pulse that arms on its last low cycle must still restart a finished run
    if (armed_q && (pin_low || st_q != ST_HOLD)) begin
      st_d = ST_HOLD;
      core_run_d = 1'b0;
      clk_en_d = 1'b0;
      ee_use_d = 1'b0;
      stable_d = 1'b0;
      halt_d = 1'b0;
      late_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_HOLD: begin
          if (armed_q) begin
            st_d = ST_STRAP;
            armed_d = 1'b0;
            cnt_d = '0;
          end
        end
        ST_STRAP: begin
          if (cnt_q == CNT_W'(STRAP_SAMPLE - 1)) begin
            // role strap reads high when left open
            straps_d = straps_now;
            ee_use_d = ctrl_ee_en_q;
            lock_d = '0;
            st_d = ctrl_ee_en_q ? ST_LOAD : ST_SETTLE;
          end
        end
        ST_LOAD: begin
          if (ee_bus.fail) begin
            st_d = ST_HALT;
            halt_d = 1'b1;
          end else if (ee_bus.ok) begin
            st_d = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          lock_d = lock_q + 1'b1;
          if (lock_q == CNT_W'(LOCK - 1)) begin
            st_d = ST_READY;
            core_run_d = 1'b1;
            clk_en_d = 1'b1;
            stable_d = 1'b1;
            late_d = (cnt_q >= bound);
          end
        end
        ST_READY: st_d = ST_READY;
        ST_HALT: st_d = ST_HALT;
        default: st_d = ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_HOLD;
      low_cnt_q <= 16'h0;
      armed_q <= 1'b0;
      cnt_q <= '0;
      lock_q <= '0;
      straps_q <= STRAP_RST;
      ee_use_q <= 1'b0;
      core_run_q <= 1'b0;
      clk_en_q <= 1'b0;
      stable_q <= 1'b0;
      halt_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      st_q <= st_d;
      low_cnt_q <= low_cnt_d;
      armed_q <= armed_d;
      cnt_q <= cnt_d;
      lock_q <= lock_d;
      straps_q <= straps_d;
      ee_use_q <= ee_use_d;
      core_run_q <= core_run_d;
      clk_en_q <= clk_en_d;
      stable_q <= stable_d;
      halt_q <= halt_d;
      late_q <= late_d;
    end
  end

  // avalon slave: waitrequest drops for one cycle per access
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status_w;
  logic [31:0] straps_w;
  logic [31:0] osc_w;
  logic req;

  assign req = avs_read | avs_write;

  always_comb begin
    status_w = 32'h0;
    status_w[ST_STATE_LSB +: 3] = st_q;
    status_w[ST_STABLE_BIT] = stable_q;
    status_w[ST_HALT_BIT] = halt_q;
    status_w[ST_LATE_BIT] = late_q;
    status_w[ST_ARMED_BIT] = armed_q;
    // loader keeps its count; hide it when this run loaded nothing
    status_w[ST_ATT_LSB +: 2] = ee_use_q ? ee_bus.attempts : 2'h0;
    straps_w = {{(32 - STRAP_W){1'b0}}, straps_q};
    osc_w = {16'h0, OSC_KHZ[straps_q[SP_OSC_LSB +: 3]]};
  end

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    ctrl_ee_en_d = ctrl_ee_en_q;
    if (req && wait_q) begin
      wait_d = 1'b0;
      unique case (avs_address)
        OFS_CTRL: rdata_d = {31'h0, ctrl_ee_en_q};
        OFS_STATUS: rdata_d = status_w;
        OFS_STRAPS: rdata_d = straps_w;
        OFS_OSC_KHZ: rdata_d = osc_w;
        OFS_ELAPSED: rdata_d = {{(32 - CNT_W){1'b0}}, cnt_q};
        default: rdata_d = 32'h0;
      endcase
    end
    // write lands on the edge where the master sees waitrequest low
    if (avs_write && !wait_q && avs_address == OFS_CTRL) begin
      ctrl_ee_en_d = avs_writedata[CTRL_EE_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      ctrl_ee_en_q <= CTRL_EE_EN_RST;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_ee_en_q <= ctrl_ee_en_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign core_reset_low = core_run_q;
  assign clk_out_enable = clk_en_q;
  assign clocks_stable = stable_q;
  assign device_halted = halt_q;
  assign strap_value = straps_q;
endmodule // rss_sequencer

//--- rss_pkg.sv
// Purpose: shared constants for the reset and strap sequencer
// Assumes: system clock of 250 MHz on clk
// Notes: times are kept in their own units; cycle counts derive from them, except LOCK_CYC, which is given in cycles
package rss_pkg;

  localparam int CLK_MHZ = 250;
  localparam int RST_MIN_US = 50;
  localparam int STRAP_HOLD_MS = 2;
  localparam int EE_LOAD_MS = 100;
  localparam int NO_EE_MS = 10;
  localparam int EE_MAX_ATTEMPTS = 3;

  // least time rounds up (exact here)
  localparam int RST_MIN_CYC = RST_MIN_US * CLK_MHZ;
  // sample in the middle of the hold window, well clear of both edges
  localparam int STRAP_SAMPLE_CYC = (STRAP_HOLD_MS * 1000 * CLK_MHZ) / 2;
  // longest times round down
  localparam int EE_LOAD_CYC = EE_LOAD_MS * 1000 * CLK_MHZ;
  localparam int NO_EE_CYC = NO_EE_MS * 1000 * CLK_MHZ;
  localparam int LOCK_CYC = 1000;
  localparam int LOAD_TIMEOUT_CYC = EE_LOAD_CYC - STRAP_SAMPLE_CYC - 2 * LOCK_CYC;

  localparam int CNT_W = 28;
  localparam int STRAP_W = 9;
  localparam int SYNC_W = STRAP_W + 1;

  // avalon register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_STRAPS = 5'h08;
  localparam logic [4:0] OFS_OSC_KHZ = 5'h0C;
  localparam logic [4:0] OFS_ELAPSED = 5'h10;

  localparam int CTRL_EE_EN_BIT = 0;
  localparam logic CTRL_EE_EN_RST = 1'b0;

  localparam int ST_STATE_LSB = 0;
  localparam int ST_STABLE_BIT = 4;
  localparam int ST_HALT_BIT = 5;
  localparam int ST_LATE_BIT = 6;
  localparam int ST_ARMED_BIT = 7;
  localparam int ST_ATT_LSB = 8;

  // strap vector layout
  localparam int SP_OSC_LSB = 0;
  localparam int SP_HOST_LSB = 3;
  localparam int SP_ADDR_LSB = 5;
  localparam int SP_ROLE_BIT = 7;
  localparam int SP_FRAME_BIT = 8;
  localparam logic [STRAP_W-1:0] STRAP_RST = 9'h080;

  // nominal oscillator frequency per strap code, kHz
  localparam logic [15:0] OSC_KHZ [8] = '{
    16'h2710, 16'h3200, 16'h32C8, 16'h4BF0,
    16'h4E20, 16'h6000, 16'h61A8, 16'h7800
  };

  typedef enum logic [2:0] {
    ST_HOLD, ST_STRAP, ST_LOAD, ST_SETTLE, ST_READY, ST_HALT
  } rss_state_e;

endpackage

//--- rss_ee_if.sv
// Purpose: carries load requests between sequencer and eeprom loader
// Assumes: one clock domain
// Notes: start is a level held for the whole load phase
`timescale 1ns/1ps
interface rss_ee_if;
  logic start;
  logic ok;
  logic fail;
  logic [1:0] attempts;
  modport seq (output start, input ok, input fail, input attempts);
  modport ldr (input start, output ok, output fail, output attempts);
endinterface

//--- rss_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static levels
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module rss_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        meta_q[i] <= RST_VAL[i];
        sync_q[i] <= RST_VAL[i];
      end else begin
        meta_q[i] <= d[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign q = sync_q;
endmodule // rss_sync

//--- rss_ee_loader.sv
// Purpose: eeprom load attempts with retry and timeout
// Assumes: ee_done and ee_err come from clk-domain logic
// Notes: a timed-out attempt counts as a bad read
`timescale 1ns/1ps
module rss_ee_loader
  import rss_pkg::*;
#(
  parameter int TIMEOUT_CYC = LOAD_TIMEOUT_CYC,
  parameter int MAX_ATT = EE_MAX_ATTEMPTS
) (
  input wire logic clk,
  input wire logic nrst,
  rss_ee_if.ldr ee,
  output logic ee_start,
  input wire logic ee_done,
  input wire logic ee_err
);
  typedef enum logic [1:0] {L_IDLE, L_BUSY, L_DONE, L_DEAD} rss_ld_e;

  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (1 << CNT_W)) begin : g_bad_timeout
    $error("bad TIMEOUT_CYC");
  end
  if (MAX_ATT < 1 || MAX_ATT > 3) begin : g_bad_att
    $error("bad MAX_ATT");
  end

  rss_ld_e st_q, st_d;
  logic [CNT_W-1:0] tmr_q, tmr_d;
  logic [1:0] att_q, att_d;
  logic start_q, start_d;

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    att_d = att_q;
    start_d = 1'b0;
    if (!ee.start) begin
      st_d = L_IDLE;
    end else begin
      unique case (st_q)
        L_IDLE: begin
          st_d = L_BUSY;
          att_d = 2'h1;
          tmr_d = '0;
          start_d = 1'b1;
        end
        L_BUSY: begin
          tmr_d = tmr_q + 1'b1;
          if (ee_done && !ee_err) begin
            st_d = L_DONE;
          end else if (ee_err || tmr_q == CNT_W'(TIMEOUT_CYC - 1)) begin
            if (att_q == 2'(MAX_ATT)) begin
              st_d = L_DEAD;
            end else begin
              att_d = att_q + 2'h1;
              tmr_d = '0;
              start_d = 1'b1;
            end
          end
        end
        L_DONE: st_d = L_DONE;
        L_DEAD: st_d = L_DEAD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= L_IDLE;
      tmr_q <= '0;
      att_q <= 2'h0;
      start_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      att_q <= att_d;
      start_q <= start_d;
    end
  end

  assign ee.ok = (st_q == L_DONE);
  assign ee.fail = (st_q == L_DEAD);
  assign ee.attempts = att_q;
  assign ee_start = start_q;
endmodule // rss_ee_loader

//--- rss_checker.sv
// Purpose: port assertions for the reset and strap sequencer
// Assumes: scaled counts handed down through the bind
// Notes: helper counts restart on every low of the reset pin
`timescale 1ns/1ps
module rss_checker
  import rss_pkg::*;
#(
  parameter int RST_MIN = 8,
  parameter int EE_BOUND = 200,
  parameter int NO_EE_BOUND = 100
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic chip_reset_low,
  input wire logic [2:0] osc_freq_select,
  input wire logic [1:0] host_port_select,
  input wire logic [1:0] bus_addr_strap,
  input wire logic redundancy_role_strap,
  input wire logic framing_standard_strap,
  input wire logic ee_start,
  input wire logic core_reset_low,
  input wire logic clk_out_enable,
  input wire logic clocks_stable,
  input wire logic device_halted,
  input wire logic [rss_pkg::STRAP_W-1:0] strap_value
);
  logic [15:0] lo_q, lo_d, hi_q, hi_d;
  logic [1:0] att_q, att_d;
  logic armed_q, armed_d;
  // raw pin counts; the sync delay only shifts both edges alike
  always_comb begin
    lo_d = 16'h0;
    hi_d = hi_q + {15'h0, hi_q != 16'hFFFF};
    att_d = att_q + {1'b0, ee_start && att_q != 2'h3};
    armed_d = armed_q;
    if (!chip_reset_low) begin
      lo_d = lo_q + {15'h0, lo_q != 16'hFFFF};
      hi_d = 16'h0;
      att_d = 2'h0;
      armed_d = lo_q >= 16'(RST_MIN - 1);
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lo_q <= 16'h0;
      hi_q <= 16'h0;
      att_q <= 2'h0;
      armed_q <= 1'b0;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      att_q <= att_d;
      armed_q <= armed_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer one cycle after request");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_gate;
    clk_out_enable == core_reset_low && clk_out_enable == clocks_stable;
  endproperty
  a_gate: assert property (p_gate) else $error("outputs released apart");
  property p_strap;
    $rose(clocks_stable) |-> strap_value == {framing_standard_strap, redundancy_role_strap,
      bus_addr_strap, host_port_select, osc_freq_select};
  endproperty
  a_strap: assert property (p_strap) else $error("captured straps differ from pins");
  property p_no_ee;
    armed_q && att_q == 2'h0 && hi_q == 16'(NO_EE_BOUND) |-> clocks_stable;
  endproperty
  a_no_ee: assert property (p_no_ee) else $error("late without load");
  property p_ee_time;
    armed_q && att_q == 2'h1 && hi_q == 16'(EE_BOUND) |-> clocks_stable;
  endproperty
  a_ee_time: assert property (p_ee_time) else $error("late with one load");
  property p_att_max;
    ee_start |-> att_q != 2'h3;
  endproperty
  a_att_max: assert property (p_att_max) else $error("fourth load attempt");
  property p_halt;
    $rose(device_halted) |-> att_q == 2'h3 && !clk_out_enable;
  endproperty
  a_halt: assert property (p_halt) else $error("halt before third failure");
endmodule // rss_checker

bind rss_sequencer rss_checker #(.RST_MIN(RST_MIN), .EE_BOUND(EE_BOUND),
  .NO_EE_BOUND(NO_EE_BOUND)) rss_checker_i (.clk, .nrst, .avs_read, .avs_write,
  .avs_waitrequest, .chip_reset_low, .osc_freq_select, .host_port_select, .bus_addr_strap,
  .redundancy_role_strap, .framing_standard_strap, .ee_start, .core_reset_low,
  .clk_out_enable, .clocks_stable, .device_halted, .strap_value);

//--- rss_board_model.sv
// Purpose: board supervisor, strap pins and config eeprom
// Assumes: at most one answer per load attempt
// Notes: failures only when a test asks for them
`timescale 1ns/1ps
module rss_board_model (
  input wire logic clk,
  output logic chip_reset_low,
  output logic [8:0] straps,
  input wire logic ee_start,
  output logic ee_done,
  output logic ee_err
);
  int fails = 0;
  int lat = 3;
  bit mute = 1'b0;
  int att = 0;
  int left = -1;
  initial begin
    chip_reset_low = 1'b0; // low until the oscillator runs
    straps = 9'h080; // role open, pulled high
    ee_done = 1'b0;
    ee_err = 1'b0;
  end
  task automatic pulse(input int n, input logic [8:0] s, input int f, input int l, input bit m);
    @(posedge clk);
    chip_reset_low <= 1'b0;
    straps <= s; // straps move only while the pin is low
    fails = f;
    lat = l;
    mute = m;
    att = 0;
    repeat (n) @(posedge clk);
    chip_reset_low <= 1'b1;
  endtask
  // muted failures never answer, so the device must time out
  always @(posedge clk) begin
    ee_done <= 1'b0;
    ee_err <= 1'b0;
    if (ee_start) left = lat;
    else if (left == 0) begin
      if (!(mute && att < fails)) begin
        ee_done <= 1'b1;
        ee_err <= att < fails;
      end
      att++;
      left = -1;
    end else if (left > 0) left--;
  end
endmodule // rss_board_model

//--- rss_sequencer_tb.sv
// Purpose: self-checking bench for the reset and strap sequencer
// Assumes: scaled counts, board model on the pins
// Notes: rows cover every oscillator code
`timescale 1ns/1ps
module rss_sequencer_tb;
  import rss_pkg::*;
  typedef struct {
    logic [8:0] straps;
    logic ee_en;
    logic [1:0] fails;
    logic [31:0] khz;
  } rss_row_s;
  localparam int RMIN = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, chip_reset_low, ee_start, ee_done, ee_err;
  logic core_reset_low, clk_out_enable, clocks_stable, device_halted;
  logic [8:0] straps, strap_value;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  rss_row_s rows [8] = '{
    '{9'h080, 1'b0, 2'h0, 32'h2710}, '{9'h189, 1'b1, 2'h0, 32'h3200},
    '{9'h0B2, 1'b1, 2'h1, 32'h32C8}, '{9'h05B, 1'b1, 2'h2, 32'h4BF0},
    '{9'h1E4, 1'b1, 2'h3, 32'h4E20}, '{9'h0ED, 1'b0, 2'h0, 32'h6000},
    '{9'h176, 1'b0, 2'h0, 32'h61A8}, '{9'h1FF, 1'b1, 2'h0, 32'h7800}};
  rss_sequencer #(.RST_MIN(RMIN), .STRAP_SAMPLE(20), .EE_BOUND(200), .NO_EE_BOUND(100),
    .LOAD_TIMEOUT(50), .LOCK(4)) rss_sequencer_i (.clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .chip_reset_low,
    .osc_freq_select(straps[2:0]), .host_port_select(straps[4:3]),
    .bus_addr_strap(straps[6:5]), .redundancy_role_strap(straps[7]),
    .framing_standard_strap(straps[8]), .ee_start, .ee_done, .ee_err, .core_reset_low,
    .clk_out_enable, .clocks_stable, .device_halted, .strap_value);
  rss_board_model rss_board_model_i (.clk, .chip_reset_low, .straps, .ee_start, .ee_done,
    .ee_err);
  always #2 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a hang would otherwise never reach the verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    // the previous run's outputs stand until the new pulse is seen
    while ((clocks_stable === 1'b1 || device_halted === 1'b1) && n < 1000) begin
      @(posedge clk);
      n++;
    end
    while (clocks_stable !== 1'b1 && device_halted !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic run_row(input rss_row_s r);
    logic [31:0] st;
    logic h;
    h = r.fails == 2'h3;
    st = h ? 32'h325 : {22'h0, r.ee_en ? r.fails + 2'h1 : 2'h0, 8'h14};
    bus(1'b1, OFS_CTRL, {31'h0, r.ee_en});
    rss_board_model_i.pulse(RMIN, r.straps, r.fails, 3, 1'b0);
    wait_done();
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h37F, st);
    bus(1'b0, OFS_STRAPS, 32'h0);
    chk(rd, {23'h0, r.straps});
    bus(1'b0, OFS_OSC_KHZ, 32'h0);
    chk(rd, r.khz);
    chk({28'h0, core_reset_low, clk_out_enable, clocks_stable, device_halted},
      h ? 32'h1 : 32'hE);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("test row %0d done", i);
    end
    // short pulse after capture: ignored, straps kept
    repeat (20) @(posedge clk);
    rss_board_model_i.pulse(RMIN - 1, 9'h000, 0, 3, 1'b0);
    repeat (40) @(posedge clk);
    chk({22'h0, clocks_stable, strap_value}, 32'h3FF);
    $display("test glitch done");
    rss_board_model_i.pulse(RMIN, 9'h080, 2, 30, 1'b1);
    wait_done();
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h37F, 32'h314);
    $display("test timeout retry done");
    bus(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    bus(1'b1, 5'h14, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h37F, 32'h314);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    $display("test refusals done");
    rss_board_model_i.pulse(RMIN, 9'h1FF, 0, 3, 1'b0);
    repeat (10) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({19'h0, core_reset_low, clk_out_enable, clocks_stable, device_halted, strap_value},
      32'h080);
    nrst <= 1'b1;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, OFS_STRAPS, 32'h0);
    chk(rd, 32'h080);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h0);
    $display("test reset done");
    close_out();
  end
endmodule // rss_sequencer_tb
